// *** hdl/lcd_scan.sv ***
// Display scan timing, retrace flag and shared cursor logic of an LCD controller.
//
// What this block does
// - Each display memory read cycle lasts exactly nine clocks.
// - Each line performs chars_per_row plus one scan read cycles.
// - Each line end pauses scan reads for total minus chars_per_row cycles.
// - Retrace flag stays high throughout that line-end pause.
// - Status read places the retrace flag on data bit 6.
// - Host commands are ignored while reset is asserted.
// - Shift clock, line latch and AC drive halt during reset.
// - Scan runs raster-like, left to right, rows top to bottom.
// - Graphics mode adds the address pitch to each line start.
// - Text mode repeats a start address per glyph row, then adds pitch.
// - Dual panel alternates upper and lower lines, one at a time.
// - Dual panel gives line latch only after the lower screen line.
// - One register is both cursor position and memory access address.
// - Each host memory access steps the cursor by the programmed step.
// - Cursor shows on first layer, or third layer in three-layer setup.
// - Cursor hidden when its address lies outside its layer region.
// - Block shape gives block over text, bar over graphics or no text.
// - Character field width accepts any value up to 16 pixels.
// - Cursor changes only by cursor write and automatic step.
// - Memory read command and each data read prefetch the next byte.
`timescale 1ns/1ps
`default_nettype none
module lcd_scan (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic [15:0] vram_addr,
  output logic [7:0] vram_wdata,
  output logic vram_we,
  output logic vram_re,
  input wire logic [7:0] vram_rdata,
  output logic [7:0] panel_data,
  output logic [3:0] char_width_m1,
  output logic x_shift_clock,
  output logic line_latch_pulse,
  output logic ac_drive_toggle,
  output logic cursor_visible,
  output logic cursor_block
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] chars_row;
    logic [7:0] total_line;
    logic [7:0] pitch;
    logic [7:0] lines;
    logic [15:0] mode;
    logic [15:0] upper_start;
    logic [15:0] lower_start;
    logic [15:0] layer1_base;
    logic [15:0] layer3_base;
    logic [15:0] layer_size;
    logic [15:0] cursor;
    logic [15:0] step;
    logic [7:0] col;
    logic [7:0] line;
    logic [3:0] glyph_row;
    logic lower_half;
    logic [15:0] line_start;
    logic [15:0] lower_line_start;
    logic wr_pend;
    logic [7:0] wr_data;
    logic rd_pend;
    logic [7:0] rd_buf;
    logic scan_slot;
    logic host_read_slot;
    logic [15:0] rdata;
    logic [15:0] vaddr;
    logic [7:0] vwdata;
    logic we;
    logic re;
    logic [7:0] pdata;
    logic xsc;
    logic lp;
    logic fr;
    logic retrace;
    logic cur_vis;
    logic cur_block;
  } scan_s;
  scan_s cur_q;
  scan_s nxt_d;

  logic [3:0] phase;
  logic slot_last;

  slot_timer #(
    .CLOCKS(lcd_scan_pkg::SLOT_CLOCKS)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .phase(phase),
    .slot_last(slot_last)
  );

  logic reading;
  logic slot_first;
  logic line_end;
  logic advance_line;
  logic [15:0] scan_base;
  logic [15:0] layer_base;
  logic in_layer;

  always_comb begin
    reading = (cur_q.col <= cur_q.chars_row);
    slot_first = (phase == 4'h0);
    line_end = slot_last && (cur_q.col == cur_q.total_line);
    advance_line = line_end && (!cur_q.mode[lcd_scan_pkg::MODE_DUAL] || cur_q.lower_half);
    scan_base = (cur_q.mode[lcd_scan_pkg::MODE_DUAL] && cur_q.lower_half) ?
      cur_q.lower_line_start : cur_q.line_start;
    layer_base = cur_q.mode[lcd_scan_pkg::MODE_THREE_LAYER] ?
      cur_q.layer3_base : cur_q.layer1_base;
    in_layer = (cur_q.cursor >= layer_base) &&
      ((cur_q.cursor - layer_base) < cur_q.layer_size);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_d = cur_q;
    nxt_d.sync1 = vram_rdata;
    nxt_d.sync2 = cur_q.sync1;
    nxt_d.rdata = 16'h0000;
    nxt_d.lp = 1'b0;
    nxt_d.re = 1'b0;
    // The shift clock keeps running through the pause so the panel sees no gap.
    nxt_d.xsc = (phase < lcd_scan_pkg::SHIFT_HIGH_PHASES);
    if (slot_last) begin
      nxt_d.we = 1'b0;
    end

    // Column and line sequencing.
    if (slot_last) begin
      if (line_end) begin
        nxt_d.col = 8'h00;
        nxt_d.lower_half = cur_q.mode[lcd_scan_pkg::MODE_DUAL] && !cur_q.lower_half;
        nxt_d.lp = advance_line;
      end else begin
        nxt_d.col = cur_q.col + 8'h01;
      end
    end

    if (advance_line) begin
      if (cur_q.mode[lcd_scan_pkg::MODE_GRAPHICS]) begin
        nxt_d.line_start = cur_q.line_start + 16'(cur_q.pitch);
        nxt_d.lower_line_start = cur_q.lower_line_start + 16'(cur_q.pitch);
      end else if (cur_q.glyph_row == cur_q.mode[lcd_scan_pkg::MODE_HEIGHT_LSB +: 4]) begin
        nxt_d.glyph_row = 4'h0;
        nxt_d.line_start = cur_q.line_start + 16'(cur_q.pitch);
        nxt_d.lower_line_start = cur_q.lower_line_start + 16'(cur_q.pitch);
      end else begin
        nxt_d.glyph_row = cur_q.glyph_row + 4'h1;
      end
      if (cur_q.line == cur_q.lines) begin
        nxt_d.line = 8'h00;
        nxt_d.glyph_row = 4'h0;
        nxt_d.line_start = cur_q.upper_start;
        nxt_d.lower_line_start = cur_q.lower_start;
        nxt_d.fr = !cur_q.fr;
      end else begin
        nxt_d.line = cur_q.line + 8'h01;
      end
    end

    // Slot start: scan read, or a host access in a pause slot.
    if (slot_first) begin
      nxt_d.scan_slot = reading;
      nxt_d.host_read_slot = 1'b0;
      if (reading) begin
        nxt_d.vaddr = scan_base + 16'(cur_q.col);
        nxt_d.re = 1'b1;
      end else if (cur_q.wr_pend) begin
        nxt_d.vaddr = cur_q.cursor;
        nxt_d.vwdata = cur_q.wr_data;
        nxt_d.we = 1'b1;
        nxt_d.wr_pend = 1'b0;
        nxt_d.cursor = cur_q.cursor + cur_q.step;
      end else if (cur_q.rd_pend) begin
        nxt_d.vaddr = cur_q.cursor;
        nxt_d.re = 1'b1;
        nxt_d.host_read_slot = 1'b1;
        nxt_d.rd_pend = 1'b0;
        nxt_d.cursor = cur_q.cursor + cur_q.step;
      end
    end

    // Data sample late in the slot, after the two-stage synchroniser.
    if (phase == lcd_scan_pkg::SAMPLE_PHASE) begin
      if (cur_q.scan_slot) begin
        nxt_d.pdata = cur_q.sync2;
        nxt_d.cur_vis = (cur_q.vaddr == cur_q.cursor) && in_layer;
      end else begin
        nxt_d.cur_vis = 1'b0;
      end
      if (cur_q.host_read_slot) begin
        nxt_d.rd_buf = cur_q.sync2;
      end
    end
    nxt_d.cur_block = cur_q.mode[lcd_scan_pkg::MODE_BLOCK] &&
      cur_q.mode[lcd_scan_pkg::MODE_TEXT_ON] &&
      !cur_q.mode[lcd_scan_pkg::MODE_GRAPHICS];

    // Host register port; set wins over the slot-service clear above.
    if (reg_write) begin
      if (reg_addr == lcd_scan_pkg::OFF_CURSOR) begin
        nxt_d.cursor = reg_wdata;
      end else if (reg_addr == lcd_scan_pkg::OFF_STEP) begin
        nxt_d.step = reg_wdata;
      end else if (reg_addr == lcd_scan_pkg::OFF_MEM_WRITE) begin
        nxt_d.wr_pend = 1'b1;
        nxt_d.wr_data = reg_wdata[7:0];
      end else if (reg_addr == lcd_scan_pkg::OFF_MEM_READ) begin
        nxt_d.rd_pend = 1'b1;
      end else if (reg_addr == lcd_scan_pkg::OFF_CHARS_ROW) begin
        nxt_d.chars_row = reg_wdata[7:0];
      end else if (reg_addr == lcd_scan_pkg::OFF_TOTAL_LINE) begin
        nxt_d.total_line = reg_wdata[7:0];
      end else if (reg_addr == lcd_scan_pkg::OFF_PITCH) begin
        nxt_d.pitch = reg_wdata[7:0];
      end else if (reg_addr == lcd_scan_pkg::OFF_LINES) begin
        nxt_d.lines = reg_wdata[7:0];
      end else if (reg_addr == lcd_scan_pkg::OFF_MODE) begin
        nxt_d.mode = reg_wdata;
      end else if (reg_addr == lcd_scan_pkg::OFF_UPPER_START) begin
        nxt_d.upper_start = reg_wdata;
      end else if (reg_addr == lcd_scan_pkg::OFF_LOWER_START) begin
        nxt_d.lower_start = reg_wdata;
      end else if (reg_addr == lcd_scan_pkg::OFF_LAYER1_BASE) begin
        nxt_d.layer1_base = reg_wdata;
      end else if (reg_addr == lcd_scan_pkg::OFF_LAYER3_BASE) begin
        nxt_d.layer3_base = reg_wdata;
      end else if (reg_addr == lcd_scan_pkg::OFF_LAYER_SIZE) begin
        nxt_d.layer_size = reg_wdata;
      end
    end
    if (reg_read) begin
      if (reg_addr == lcd_scan_pkg::OFF_STATUS) begin
        nxt_d.rdata[lcd_scan_pkg::RETRACE_BIT] = cur_q.retrace;
      end else if (reg_addr == lcd_scan_pkg::OFF_CURSOR) begin
        nxt_d.rdata = cur_q.cursor;
      end else if (reg_addr == lcd_scan_pkg::OFF_MEM_READ) begin
        nxt_d.rdata = {8'h00, cur_q.rd_buf};
        nxt_d.rd_pend = 1'b1;
      end else if (reg_addr == lcd_scan_pkg::OFF_MODE) begin
        nxt_d.rdata = cur_q.mode;
      end else if (reg_addr == lcd_scan_pkg::OFF_CHARS_ROW) begin
        nxt_d.rdata = {8'h00, cur_q.chars_row};
      end else if (reg_addr == lcd_scan_pkg::OFF_TOTAL_LINE) begin
        nxt_d.rdata = {8'h00, cur_q.total_line};
      end else if (reg_addr == lcd_scan_pkg::OFF_STEP) begin
        nxt_d.rdata = cur_q.step;
      end else if (reg_addr == lcd_scan_pkg::OFF_PITCH) begin
        nxt_d.rdata = {8'h00, cur_q.pitch};
      end else if (reg_addr == lcd_scan_pkg::OFF_LINES) begin
        nxt_d.rdata = {8'h00, cur_q.lines};
      end else if (reg_addr == lcd_scan_pkg::OFF_UPPER_START) begin
        nxt_d.rdata = cur_q.upper_start;
      end else if (reg_addr == lcd_scan_pkg::OFF_LOWER_START) begin
        nxt_d.rdata = cur_q.lower_start;
      end else if (reg_addr == lcd_scan_pkg::OFF_LAYER1_BASE) begin
        nxt_d.rdata = cur_q.layer1_base;
      end else if (reg_addr == lcd_scan_pkg::OFF_LAYER3_BASE) begin
        nxt_d.rdata = cur_q.layer3_base;
      end else if (reg_addr == lcd_scan_pkg::OFF_LAYER_SIZE) begin
        nxt_d.rdata = cur_q.layer_size;
      end
    end
    // Worked out last, so a new chars_row moves the flag with the column in the same cycle.
    nxt_d.retrace = !(nxt_d.col <= nxt_d.chars_row);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      cur_q <= '0;
      cur_q.chars_row <= lcd_scan_pkg::RST_CHARS_ROW;
      cur_q.total_line <= lcd_scan_pkg::RST_TOTAL_LINE;
      cur_q.pitch <= lcd_scan_pkg::RST_PITCH;
      cur_q.lines <= lcd_scan_pkg::RST_LINES;
      cur_q.mode <= lcd_scan_pkg::RST_MODE;
      cur_q.step <= lcd_scan_pkg::RST_STEP;
      cur_q.layer_size <= lcd_scan_pkg::RST_LAYER_SIZE;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign reg_rdata = cur_q.rdata;
  assign vram_addr = cur_q.vaddr;
  assign vram_wdata = cur_q.vwdata;
  assign vram_we = cur_q.we;
  assign vram_re = cur_q.re;
  assign panel_data = cur_q.pdata;
  assign char_width_m1 = cur_q.mode[lcd_scan_pkg::MODE_WIDTH_LSB +: 4];
  assign x_shift_clock = cur_q.xsc;
  assign line_latch_pulse = cur_q.lp;
  assign ac_drive_toggle = cur_q.fr;
  assign cursor_visible = cur_q.cur_vis;
  assign cursor_block = cur_q.cur_block;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_write_in_pause: assert property (@(posedge clock) disable iff (rst)
    vram_we |-> !cur_q.scan_slot && cur_q.retrace) else $error("write overlaps scan slot");
  a_write_length: assert property (@(posedge clock) disable iff (rst)
    $rose(vram_we) |-> vram_we [*8] ##1 !vram_we) else $error("write strobe not eight clocks");
  a_retrace_flag: assert property (@(posedge clock) disable iff (rst)
    cur_q.retrace == !(cur_q.col <= cur_q.chars_row)) else $error("retrace flag wrong");
  a_status_bit: assert property (@(posedge clock) disable iff (rst)
    reg_read && reg_addr == lcd_scan_pkg::OFF_STATUS |=>
    reg_rdata[6] == $past(cur_q.retrace)) else $error("status bit 6 wrong");
  a_halt_reset: assert property (@(posedge clock)
    rst |=> !line_latch_pulse && !x_shift_clock && !ac_drive_toggle) else $error("drive not halted");
  a_latch_line_end: assert property (@(posedge clock) disable iff (rst)
    line_latch_pulse |-> cur_q.col == 8'h00 && $past(cur_q.col) == cur_q.total_line)
    else $error("latch not at line end");
  a_latch_dual: assert property (@(posedge clock) disable iff (rst)
    line_latch_pulse && cur_q.mode[lcd_scan_pkg::MODE_DUAL] |-> !cur_q.lower_half)
    else $error("latch after upper line");
  a_cursor_step: assert property (@(posedge clock) disable iff (rst)
    $rose(vram_we) && !$past(reg_write) |-> cur_q.cursor == $past(cur_q.cursor) + cur_q.step)
    else $error("cursor not stepped");
  a_cursor_hold: assert property (@(posedge clock) disable iff (rst)
    !$past(reg_write) && !$rose(vram_we) && !(vram_re && cur_q.host_read_slot) |->
    $stable(cur_q.cursor)) else $error("cursor changed");
endmodule
`default_nettype wire

// *** hdl/lcd_scan_pkg.sv ***
// Package with offsets, field positions, reset values and slot timing of the LCD scan block.
package lcd_scan_pkg;
  // ----------------------------------------
  // Slot timing
  // ----------------------------------------
  localparam int SLOT_CLOCKS = 9;
  localparam logic [3:0] SAMPLE_PHASE = 4'h8;
  localparam logic [3:0] SHIFT_HIGH_PHASES = 4'h4;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_CURSOR = 4'h1;
  localparam logic [3:0] OFF_STEP = 4'h2;
  localparam logic [3:0] OFF_MEM_WRITE = 4'h3;
  localparam logic [3:0] OFF_MEM_READ = 4'h4;
  localparam logic [3:0] OFF_CHARS_ROW = 4'h5;
  localparam logic [3:0] OFF_TOTAL_LINE = 4'h6;
  localparam logic [3:0] OFF_PITCH = 4'h7;
  localparam logic [3:0] OFF_LINES = 4'h8;
  localparam logic [3:0] OFF_MODE = 4'h9;
  localparam logic [3:0] OFF_UPPER_START = 4'ha;
  localparam logic [3:0] OFF_LOWER_START = 4'hb;
  localparam logic [3:0] OFF_LAYER1_BASE = 4'hc;
  localparam logic [3:0] OFF_LAYER3_BASE = 4'hd;
  localparam logic [3:0] OFF_LAYER_SIZE = 4'he;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RETRACE_BIT = 6;
  localparam int MODE_GRAPHICS = 0;
  localparam int MODE_DUAL = 1;
  localparam int MODE_THREE_LAYER = 2;
  localparam int MODE_BLOCK = 3;
  localparam int MODE_TEXT_ON = 4;
  localparam int MODE_HEIGHT_LSB = 8;
  localparam int MODE_WIDTH_LSB = 12;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CHARS_ROW = 8'h27;
  localparam logic [7:0] RST_TOTAL_LINE = 8'h2f;
  localparam logic [7:0] RST_PITCH = 8'h28;
  localparam logic [7:0] RST_LINES = 8'hef;
  localparam logic [15:0] RST_MODE = 16'h7710;
  localparam logic [15:0] RST_STEP = 16'h0001;
  localparam logic [15:0] RST_LAYER_SIZE = 16'h2580;
endpackage

// *** hdl/slot_timer.sv ***
// Nine-clock read-cycle slot timer.
`timescale 1ns/1ps
`default_nettype none
module slot_timer #(
  parameter int CLOCKS = lcd_scan_pkg::SLOT_CLOCKS
) (
  input wire logic clock,
  input wire logic rst,
  output logic [3:0] phase,
  output logic slot_last
);
  typedef struct packed {
    logic [3:0] phase;
  } timer_s;
  timer_s cur_q;
  timer_s nxt_d;

  // Memory data needs the sample phase plus two synchroniser stages inside one slot.
  if (CLOCKS < 9 || CLOCKS > 16) begin : g_check
    $error("slot_timer: CLOCKS must lie between 9 and 16");
  end

  always_comb begin
    nxt_d = cur_q;
    if (cur_q.phase == 4'(CLOCKS - 1)) begin
      nxt_d.phase = 4'h0;
    end else begin
      nxt_d.phase = cur_q.phase + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign phase = cur_q.phase;
  assign slot_last = (cur_q.phase == 4'(CLOCKS - 1));

  a_slot_length: assert property (@(posedge clock) disable iff (rst)
    slot_last |=> !slot_last [*8] ##1 slot_last) else $error("slot is not nine clocks");
endmodule
`default_nettype wire

// *** bench/vram_model.sv ***
// Display memory model that answers the scan block's memory port.
`timescale 1ns/1ps
`default_nettype none
module vram_model (
  input wire logic clock,
  input wire logic [15:0] vram_addr,
  input wire logic [7:0] vram_wdata,
  input wire logic vram_we,
  output logic [7:0] vram_rdata
);
  logic [7:0] mem [0:65535];
  // -------------------------------
  // Storage
  // -------------------------------
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h3c;
    end
  end
  always @(posedge clock) begin
    if (vram_we) begin
      mem[vram_addr] <= vram_wdata;
    end
  end
  // While the block drives the data lines no stored byte shows, so a late sample is caught.
  assign vram_rdata = vram_we ? ~vram_wdata : mem[vram_addr];
endmodule
`default_nettype wire

// *** bench/lcd_display_scan_cursor_tb_top.sv ***
// Self-checking bench of the LCD scan block with a display memory model.
`timescale 1ns/1ps
`default_nettype none
module lcd_display_scan_cursor_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic trk = 1'b0;
  logic [15:0] reg_rdata, vram_addr;
  logic [7:0] vram_wdata, vram_rdata, panel_data;
  logic vram_we, vram_re, x_shift_clock, line_latch_pulse, ac_drive_toggle;
  logic cursor_visible, cursor_block;
  logic [3:0] char_width_m1;
  int miscompares = 0;
  int cmp_count = 0;
  int flag_cnt = 0;
  logic pend_q = 1'b0;
  logic poll_q = 1'b0;
  logic we_q = 1'b0;
  logic [15:0] rq [$];
  logic [23:0] wq [$];
  logic [23:0] w;
  logic [31:0] rng = 32'h0000_0053;
  logic [3:0] ra [9] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'he, 4'hf};
  logic [15:0] rv [9] = '{16'h0000, 16'h0001, 16'h0027, 16'h002f, 16'h0028, 16'h00ef,
                          16'h7710, 16'h2580, 16'h0000};
  always #2.5 clock = ~clock;
  lcd_scan DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .vram_addr(vram_addr), .vram_wdata(vram_wdata), .vram_we(vram_we), .vram_re(vram_re),
    .vram_rdata(vram_rdata), .panel_data(panel_data), .char_width_m1(char_width_m1),
    .x_shift_clock(x_shift_clock), .line_latch_pulse(line_latch_pulse),
    .ac_drive_toggle(ac_drive_toggle), .cursor_visible(cursor_visible),
    .cursor_block(cursor_block));
  vram_model mem_side (.clock(clock), .vram_addr(vram_addr), .vram_wdata(vram_wdata),
    .vram_we(vram_we), .vram_rdata(vram_rdata));
  // -------------------------------
  // Shared tasks
  // -------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic rd, input logic [3:0] a, input logic [15:0] d,
                     input logic t);
    reg_write <= wr;
    reg_read <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    trk <= t;
    @(posedge clock);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d, 1'b0);
    bus(1'b0, 1'b0, a, d, 1'b0);
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
    rq.push_back(e);
    bus(1'b0, 1'b1, a, 16'h0000, 1'b1);
    bus(1'b0, 1'b0, a, 16'h0000, 1'b0);
  endtask
  task automatic wait_ll(output int n, output int r);
    n = 0;
    r = 0;
    do begin
      @(posedge clock);
      n++;
      r += (vram_re === 1'b1);
    end while (line_latch_pulse !== 1'b1 && n < 5000);
    check(n < 5000, 1);
  endtask
  task automatic wait_we();
    int k;
    int h;
    k = 0;
    h = 0;
    while (vram_we !== 1'b1 && k < 1000) begin
      @(posedge clock);
      k++;
    end
    while (vram_we !== 1'b0 && k < 1000) begin
      @(posedge clock);
      k++;
      h++;
    end
    check(h, 8);
  endtask
  // -------------------------------
  // Output watcher
  // -------------------------------
  always @(posedge clock) begin
    pend_q <= reg_read && trk;
    poll_q <= reg_read && !trk;
    we_q <= vram_we;
    if (poll_q && reg_rdata[6] === 1'b1) flag_cnt++;
    if (pend_q) check(reg_rdata, rq.pop_front());
    if (vram_we === 1'b1 && !we_q) begin
      if (wq.size() == 0) begin
        check(vram_we, 0);
      end else begin
        w = wq.pop_front();
        check(vram_addr, w[23:8]);
        check(vram_wdata, w[7:0]);
      end
    end
  end
  // -------------------------------
  // Main sequence
  // -------------------------------
  initial begin
    int n;
    int r;
    int h;
    logic [31:0] x;
    logic [15:0] s;
    logic [15:0] m;
    logic [15:0] e;
    repeat (2) @(posedge clock);
    reg_wr(4'h5, 16'h0003);
    repeat (6) begin
      @(posedge clock);
      check({x_shift_clock, line_latch_pulse, ac_drive_toggle}, 0);
    end
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 9; i++) reg_rd(ra[i], rv[i]);
    $display("test reset values done");
    h = 0;
    while (x_shift_clock !== 1'b1 && h < 100) begin
      @(posedge clock);
      h++;
    end
    h = 0;
    repeat (9) begin
      h += (x_shift_clock === 1'b1);
      @(posedge clock);
    end
    check(h, 4);
    check(x_shift_clock, 1);
    $display("test shift clock done");
    reg_wr(4'h5, 16'h0003);
    reg_wr(4'h6, 16'h0007);
    reg_wr(4'h8, 16'h0003);
    reg_wr(4'h7, 16'h0010);
    reg_wr(4'ha, 16'h1000);
    wait_ll(n, r);
    wait_ll(n, r);
    check(n, 72);
    check(r, 4);
    wait_ll(n, r);
    flag_cnt = 0;
    repeat (72) bus(1'b0, 1'b1, 4'h0, 16'h0000, 1'b0);
    bus(1'b0, 1'b0, 4'h0, 16'h0000, 1'b0);
    @(posedge clock);
    check(flag_cnt, 36);
    $display("test line timing done");
    x = xs();
    s = 16'(x[1:0]) + 16'h0001;
    reg_wr(4'h2, s);
    reg_wr(4'h1, 16'h0100);
    wait_ll(n, r);
    repeat (45) @(posedge clock);
    wq.push_back({16'h0100, x[15:8]});
    reg_wr(4'h3, {8'h00, x[15:8]});
    wait_we();
    wq.push_back({16'h0100 + s, x[23:16]});
    reg_wr(4'h3, {8'h00, x[23:16]});
    wait_we();
    reg_rd(4'h1, 16'h0100 + s + s);
    $display("test memory write done");
    reg_wr(4'h1, 16'h0100);
    reg_wr(4'h4, 16'h0000);
    repeat (2) wait_ll(n, r);
    reg_rd(4'h4, {8'h00, x[15:8]});
    repeat (2) wait_ll(n, r);
    reg_rd(4'h4, {8'h00, x[23:16]});
    $display("test memory read done");
    repeat (2) wait_ll(n, r);
    reg_wr(4'h1, 16'h1001);
    reg_wr(4'hb, 16'h2000);
    for (int t = 0; t < 3; t++) begin
      m = (t == 2) ? 16'h0003 : ((t == 1) ? 16'h0118 : 16'hf009);
      reg_wr(4'h9, m);
      reg_wr(4'hc, (t == 1) ? 16'h2000 : 16'h0000);
      h = 0;
      @(posedge clock);
      e = {15'h0000, ac_drive_toggle};
      while (ac_drive_toggle === e[0] && h < 2000) begin
        @(posedge clock);
        h++;
      end
      for (int j = 0; j < 12; j++) begin
        while (vram_re !== 1'b1 && h < 4000) begin
          @(posedge clock);
          h++;
        end
        if (t == 2) begin
          e = ((j / 4) % 2 == 1) ? 16'h2000 : 16'h1000;
          e = e + 16'(j % 4) + 16'h0010 * 16'(j / 8);
        end else begin
          e = 16'h1000 + 16'(j % 4) + 16'h0010 * 16'((t == 1) ? (j / 8) : (j / 4));
        end
        check(vram_addr, e);
        repeat (8) @(posedge clock);
        check(panel_data, e[7:0] ^ 8'h3c);
        check(cursor_visible, (t != 1) && (e == 16'h1001));
      end
      check(char_width_m1, m[15:12]);
      check(cursor_block, t == 1);
      if (t == 2) begin
        wait_ll(n, r);
        wait_ll(n, r);
        check(n, 144);
      end
    end
    $display("test scan modes done");
    report_and_stop();
  end
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
